// File: verilog/wdg_mode_status.sv
// wdg_mode_status: mode select, overflow flag, interrupt enable and the
// 8-bit up-counter of an interval/watchdog timer, behind an apb slave.
// assumes count tick, run enable and reset-select come from neighbour
// logic on the same clock, so none of them is synchronised.
`timescale 1ns/1ps
`default_nettype none

module wdg_mode_status (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // neighbour timer logic
  input  wire logic        count_tick_in,
  input  wire logic        count_run_enable_in,
  input  wire logic        int_reset_select_in,
  // results
  output logic             overflow_pulse_out,
  output logic             interval_irq_out,
  output logic             internal_reset_req_out,
  output logic             timer_mode_select_out,
  output logic             irq_out
);
  import wdg_pkg::*;

  typedef struct packed {
    logic        timer_mode_select;
    logic        overflow_irq_enable;
    logic        overflow_flag;
    logic        clear_armed;
    logic        int_reset_req;
    logic        interval_irq;
    logic        overflow_pulse;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } wdg_state_t;

  wdg_state_t st_q;
  wdg_state_t st_d;

  // sub-block wires
  logic [WDG_CNT_W-1:0] cnt_val;
  logic                 cnt_wrap;
  logic [WDG_EV_W-1:0]  ev_sts;
  logic [WDG_EV_W-1:0]  ev_msk;
  logic                 ev_irq;

  // bus decode
  logic                 setup_ph;
  logic                 access_done;
  logic                 wr_done;
  logic                 rd_done;
  logic                 hit_ctrl2;
  logic                 hit_counter;
  logic                 hit_sts;
  logic                 hit_msk;
  logic                 hit_any;
  logic                 cnt_load;
  logic                 msk_load;
  logic [WDG_EV_W-1:0]  sts_clear;
  logic [WDG_EV_W-1:0]  ev_set;
  logic [7:0]           ctrl2_view;

  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && st_q.ready;
  assign wr_done     = access_done && pwrite;
  assign rd_done     = access_done && !pwrite;
  assign hit_ctrl2   = (paddr == WDG_ADDR_CTRL2);
  assign hit_counter = (paddr == WDG_ADDR_COUNTER);
  assign hit_sts     = (paddr == WDG_ADDR_IRQ_STS);
  assign hit_msk     = (paddr == WDG_ADDR_IRQ_MSK);
  assign hit_any     = hit_ctrl2 || hit_counter || hit_sts || hit_msk;

  // counter write lands at the completing edge, any time
  assign cnt_load = wr_done && hit_counter;
  assign msk_load = wr_done && hit_msk;

  // read-to-clear covers only the bits that the read actually returned
  assign sts_clear = (rd_done && hit_sts) ? st_q.rdata[WDG_EV_W-1:0]
                                          : WDG_EV_ZERO;

  always_comb begin
    ev_set                 = WDG_EV_ZERO;
    ev_set[WDG_EV_OVF]     = cnt_wrap;
    ev_set[WDG_EV_INT_RST] = st_q.int_reset_req;
  end

  // write-disable bits and reserved bits always read as 1
  always_comb begin
    ctrl2_view                  = 8'hFF;
    ctrl2_view[WDG_BIT_OVF]     = st_q.overflow_flag;
    ctrl2_view[WDG_BIT_MODE_WD] = 1'b1;
    ctrl2_view[WDG_BIT_MODE]    = st_q.timer_mode_select;
    ctrl2_view[WDG_BIT_IE_WD]   = 1'b1;
    ctrl2_view[WDG_BIT_IE]      = st_q.overflow_irq_enable;
    ctrl2_view[2:0]             = WDG_RSVD_VAL;
  end

  wdg_counter u_counter (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (count_tick_in),
    .run_in      (count_run_enable_in),
    .load_in     (cnt_load),
    .load_val_in (pwdata[WDG_CNT_W-1:0]),
    .count_out   (cnt_val),
    .wrap_out    (cnt_wrap)
  );

  wdg_irq u_irq (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .event_in    (ev_set),
    .clear_in    (sts_clear),
    .mask_wr_in  (msk_load),
    .mask_val_in (pwdata[WDG_EV_W-1:0]),
    .status_out  (ev_sts),
    .mask_out    (ev_msk),
    .irq_out     (ev_irq)
  );

  always_comb begin
    st_d                = st_q;
    st_d.overflow_pulse = cnt_wrap;
    st_d.int_reset_req  = 1'b0;

    // apb: one wait-free access phase; ready raised for the access cycle
    st_d.ready  = setup_ph;
    st_d.slverr = setup_ph && !hit_any;
    if (setup_ph) begin
      st_d.rdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_ctrl2) begin
          st_d.rdata[7:0] = ctrl2_view;
        end else if (hit_counter) begin
          st_d.rdata[WDG_CNT_W-1:0] = cnt_val;
        end else if (hit_sts) begin
          st_d.rdata[WDG_EV_W-1:0] = ev_sts;
        end else if (hit_msk) begin
          st_d.rdata[WDG_EV_W-1:0] = ev_msk;
        end
      end
    end

    // a read that returned the flag as 1 arms the clear
    if (rd_done && hit_ctrl2 && st_q.rdata[WDG_BIT_OVF]) begin
      st_d.clear_armed = 1'b1;
    end

    if (wr_done && hit_ctrl2) begin
      if (!pwdata[WDG_BIT_MODE_WD]) begin
        st_d.timer_mode_select = pwdata[WDG_BIT_MODE];
      end
      if (!pwdata[WDG_BIT_IE_WD]) begin
        st_d.overflow_irq_enable = pwdata[WDG_BIT_IE];
      end
      // writing 1 to the flag never sets it
      if (!pwdata[WDG_BIT_OVF] && st_q.clear_armed) begin
        st_d.overflow_flag = 1'b0;
      end
      st_d.clear_armed = 1'b0;
    end

    // the internal reset raised by a watchdog overflow takes the flag down
    if (st_q.int_reset_req) begin
      st_d.overflow_flag = 1'b0;
      st_d.clear_armed   = 1'b0;
    end

    // a wrap in the clearing cycle is not lost
    if (cnt_wrap) begin
      st_d.overflow_flag = 1'b1;
      if (st_q.timer_mode_select == WDG_MODE_WATCHDOG &&
          int_reset_select_in) begin
        st_d.int_reset_req = 1'b1;
      end
    end

    st_d.interval_irq = st_d.overflow_flag &&
      (st_d.timer_mode_select == WDG_MODE_INTERVAL) &&
      st_d.overflow_irq_enable;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '{timer_mode_select:   WDG_MODE_WATCHDOG,
                overflow_irq_enable: 1'b0,
                overflow_flag:       1'b0,
                clear_armed:         1'b0,
                int_reset_req:       1'b0,
                interval_irq:        1'b0,
                overflow_pulse:      1'b0,
                ready:               1'b0,
                slverr:              1'b0,
                rdata:               32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata                 = st_q.rdata;
  assign pready                 = st_q.ready;
  assign pslverr                = st_q.slverr;
  assign overflow_pulse_out     = st_q.overflow_pulse;
  assign interval_irq_out       = st_q.interval_irq;
  assign internal_reset_req_out = st_q.int_reset_req;
  assign timer_mode_select_out  = st_q.timer_mode_select;
  assign irq_out                = ev_irq;

endmodule

`default_nettype wire

// File: verilog/wdg_pkg.sv
// wdg_pkg: shared constants and types for the watchdog mode/status and
// counter block. assumes a 32-bit apb slave, one register per word.
`default_nettype none

package wdg_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] WDG_IDX_CTRL2   = 32'h0000_FFB2;
  localparam logic [31:0] WDG_IDX_COUNTER = 32'h0000_FFB3;
  localparam logic [31:0] WDG_IDX_IRQ_STS = 32'h0000_FFB4;
  localparam logic [31:0] WDG_IDX_IRQ_MSK = 32'h0000_FFB5;
  localparam logic [31:0] WDG_ADDR_CTRL2   = WDG_IDX_CTRL2   << 2;
  localparam logic [31:0] WDG_ADDR_COUNTER = WDG_IDX_COUNTER << 2;
  localparam logic [31:0] WDG_ADDR_IRQ_STS = WDG_IDX_IRQ_STS << 2;
  localparam logic [31:0] WDG_ADDR_IRQ_MSK = WDG_IDX_IRQ_MSK << 2;

  // control/status two field positions
  localparam int WDG_BIT_OVF       = 7;
  localparam int WDG_BIT_MODE_WD   = 6;
  localparam int WDG_BIT_MODE      = 5;
  localparam int WDG_BIT_IE_WD     = 4;
  localparam int WDG_BIT_IE        = 3;
  localparam logic [2:0] WDG_RSVD_VAL = 3'h7;

  // counter
  localparam int         WDG_CNT_W     = 8;
  localparam logic [7:0] WDG_CNT_MAX   = 8'hFF;
  localparam logic [7:0] WDG_CNT_RESET = 8'h00;

  // interrupt status bits
  localparam int         WDG_EV_W       = 2;
  localparam int         WDG_EV_OVF     = 0;
  localparam int         WDG_EV_INT_RST = 1;
  localparam logic [1:0] WDG_EV_ZERO    = 2'h0;

  typedef enum logic {
    WDG_MODE_WATCHDOG = 1'b0,
    WDG_MODE_INTERVAL = 1'b1
  } wdg_mode_t;

endpackage

`default_nettype wire

// File: verilog/wdg_counter.sv
// wdg_counter: 8-bit up-counter with load and wrap pulse.
// assumes tick and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module wdg_counter (
  // clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rstn_in,
  // counting
  input  wire logic                          tick_in,
  input  wire logic                          run_in,
  // software load
  input  wire logic                          load_in,
  input  wire logic [wdg_pkg::WDG_CNT_W-1:0] load_val_in,
  // state
  output logic      [wdg_pkg::WDG_CNT_W-1:0] count_out,
  output logic                               wrap_out
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [WDG_CNT_W-1:0] cnt;
    logic                 wrap;
  } wdg_cnt_state_t;

  wdg_cnt_state_t st_q;
  wdg_cnt_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.wrap = 1'b0;
    // a software load beats a tick in the same cycle
    if (load_in) begin
      st_d.cnt = load_val_in;
    end else if (tick_in && run_in) begin
      st_d.cnt  = st_q.cnt + 8'h01;
      st_d.wrap = (st_q.cnt == WDG_CNT_MAX);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '{cnt: WDG_CNT_RESET, wrap: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign count_out = st_q.cnt;
  assign wrap_out  = st_q.wrap;

endmodule

`default_nettype wire

// File: verilog/wdg_irq.sv
// wdg_irq: sticky event bits, mask and one level interrupt.
// assumes clear bits come from a completed read of the status word.
`timescale 1ns/1ps
`default_nettype none

module wdg_irq (
  // clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         rstn_in,
  // events and software
  input  wire logic [wdg_pkg::WDG_EV_W-1:0] event_in,
  input  wire logic [wdg_pkg::WDG_EV_W-1:0] clear_in,
  input  wire logic                         mask_wr_in,
  input  wire logic [wdg_pkg::WDG_EV_W-1:0] mask_val_in,
  // state
  output logic      [wdg_pkg::WDG_EV_W-1:0] status_out,
  output logic      [wdg_pkg::WDG_EV_W-1:0] mask_out,
  output logic                              irq_out
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [WDG_EV_W-1:0] sts;
    logic [WDG_EV_W-1:0] msk;
    logic                irq;
  } wdg_irq_state_t;

  wdg_irq_state_t st_q;
  wdg_irq_state_t st_d;
  logic [WDG_EV_W-1:0] sts_next;

  // set wins over a read clear in the same cycle
  always_comb begin
    sts_next = (st_q.sts & ~clear_in) | event_in;
    st_d     = st_q;
    st_d.sts = sts_next;
    if (mask_wr_in) begin
      st_d.msk = mask_val_in;
    end
    st_d.irq = |(sts_next & st_d.msk);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '{sts: WDG_EV_ZERO, msk: WDG_EV_ZERO, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign status_out = st_q.sts;
  assign mask_out   = st_q.msk;
  assign irq_out    = st_q.irq;

endmodule

`default_nettype wire

// File: verif/wdg_ms_sva.sv
// wdg_ms_sva: port-level checks for wdg_mode_status, bound to it.
// assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module wdg_ms_sva (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // neighbour logic
  input wire logic        count_tick_in,
  input wire logic        count_run_enable_in,
  input wire logic        int_reset_select_in,
  // results
  input wire logic        overflow_pulse_out,
  input wire logic        interval_irq_out,
  input wire logic        internal_reset_req_out,
  input wire logic        timer_mode_select_out,
  input wire logic        irq_out
);
  import wdg_pkg::*;
  logic wr_mode;
  logic adv;
  assign wr_mode = psel && penable && pready && pwrite &&
                   paddr == WDG_ADDR_CTRL2 && !pwdata[WDG_BIT_MODE_WD];
  assign adv = count_tick_in && count_run_enable_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_setup;
    psel && !penable;
  endsequence
  // mode and reset-select are judged in the cycle the wrap was seen
  sequence s_wd_wrap;
    overflow_pulse_out && !$past(timer_mode_select_out) &&
      $past(int_reset_select_in);
  endsequence
  // the request rises together with the wrap pulse and lasts one cycle
  sequence s_rst_pulse;
    internal_reset_req_out ##1 !internal_reset_req_out;
  endsequence
  AST_SETUP_READY: assert property (s_setup |=> pready)
    else $error("no pready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // output is the register itself; a write two cycles back is accepted as well
  AST_MODE_HOLD: assert property ($changed(timer_mode_select_out) |->
    $past(wr_mode) || $past(wr_mode, 2))
    else $error("mode changed without enabled write");
  AST_WRAP_CAUSE: assert property (overflow_pulse_out |->
    $past(adv) || $past(adv, 2))
    else $error("wrap pulse without tick and run");
  AST_WRAP_ONCE: assert property (overflow_pulse_out |=> !overflow_pulse_out)
    else $error("wrap pulse too long");
  AST_RST_AFTER_WRAP: assert property (s_wd_wrap |-> s_rst_pulse)
    else $error("no reset request after watchdog wrap");
  AST_RST_CAUSE: assert property (internal_reset_req_out |->
    overflow_pulse_out && !$past(timer_mode_select_out) &&
    $past(int_reset_select_in))
    else $error("reset request without wrap");
  AST_IRQ_MODE: assert property (interval_irq_out |->
    timer_mode_select_out || $past(timer_mode_select_out))
    else $error("interval request outside interval mode");
endmodule

bind wdg_mode_status wdg_ms_sva u_sva (.ref_clk_in, .rstn_in, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .count_tick_in, .count_run_enable_in, .int_reset_select_in,
  .overflow_pulse_out, .interval_irq_out, .internal_reset_req_out,
  .timer_mode_select_out, .irq_out);

`default_nettype wire

// File: verif/tb_top.sv
// tb_top: self-checking bench for wdg_mode_status over apb.
// assumes the checker file is compiled alongside for its bind.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wdg_pkg::*;
  localparam logic [31:0] C2 = WDG_ADDR_CTRL2;
  localparam logic [31:0] CN = WDG_ADDR_COUNTER;
  localparam logic [31:0] ST = WDG_ADDR_IRQ_STS;
  localparam logic [31:0] MK = WDG_ADDR_IRQ_MSK;
  logic        ref_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, seed, rd;
  logic        count_tick_in, count_run_enable_in, int_reset_select_in;
  logic        overflow_pulse_out, interval_irq_out, internal_reset_req_out;
  logic        timer_mode_select_out, irq_out, err;
  int          fail_count, num_checks, n_wrap, n_rreq;

  wdg_mode_status u_dut (.ref_clk_in, .rstn_in, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .count_tick_in,
    .count_run_enable_in, .int_reset_select_in, .overflow_pulse_out,
    .interval_irq_out, .internal_reset_req_out, .timer_mode_select_out,
    .irq_out);

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // pulses are counted, not waited for, so no exact latency is assumed
  always @(posedge ref_clk_in) begin
    if (overflow_pulse_out === 1'b1) n_wrap++;
    if (internal_reset_req_out === 1'b1) n_rreq++;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] ctl(input logic f, m, e);
    return {24'h0, f, 1'b1, m, 1'b1, e, WDG_RSVD_VAL};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d);
    int i;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk_in);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 16) begin
      fail_count++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      count_tick_in <= 1'b1;
      @(posedge ref_clk_in);
      count_tick_in <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_in);
  endtask

  initial begin
    {psel, penable, pwrite, count_tick_in, count_run_enable_in} = 5'h0;
    int_reset_select_in = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    seed = 32'h30;
    rstn_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rchk(C2, ctl(0, 0, 0), "ctrl2 reset");
    rchk(CN, 32'h0, "counter reset");
    chk("mode out", 32'h0, timer_mode_select_out);
    apb(1'b1, C2, 32'h78);
    rchk(C2, ctl(0, 0, 0), "ctrl2 disabled");
    apb(1'b1, C2, 32'h28);
    rchk(C2, ctl(0, 1, 1), "ctrl2 enabled");
    chk("mode out", 32'h1, timer_mode_select_out);
    // run low: random loads must read back untouched by ticks
    repeat (6) begin
      seed = nxt(seed);
      apb(1'b1, CN, {24'h0, seed[7:0]});
      ticks(1);
      rchk(CN, {24'h0, seed[7:0]}, "counter");
    end
    rchk(32'h0, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, err);
    count_run_enable_in <= 1'b1;
    apb(1'b1, CN, 32'hFE);
    ticks(2);
    chk("wraps", 32'h1, n_wrap);
    rchk(CN, 32'h0, "counter wrap");
    chk("interval irq", 32'h1, interval_irq_out);
    chk("irq masked", 32'h0, irq_out);
    apb(1'b1, MK, 32'h3);
    repeat (2) @(posedge ref_clk_in);
    chk("irq unmasked", 32'h1, irq_out);
    rchk(ST, 32'h1, "status");
    repeat (2) @(posedge ref_clk_in);
    chk("irq cleared", 32'h0, irq_out);
    apb(1'b1, C2, 32'h48);
    rchk(C2, ctl(1, 1, 1), "flag unarmed");
    apb(1'b1, C2, 32'hC8);
    rchk(C2, ctl(1, 1, 1), "flag write one");
    apb(1'b1, C2, 32'h48);
    rchk(C2, ctl(0, 1, 1), "flag cleared");
    chk("interval irq off", 32'h0, interval_irq_out);
    apb(1'b1, C2, 32'h40);
    apb(1'b1, CN, 32'hFF);
    ticks(1);
    chk("irq disabled", 32'h0, interval_irq_out);
    rchk(C2, ctl(1, 1, 0), "flag no ie");
    apb(1'b1, C2, 32'h40);
    apb(1'b1, C2, 32'h00);
    int_reset_select_in <= 1'b1;
    apb(1'b1, CN, 32'hFF);
    ticks(1);
    chk("reset reqs", 32'h1, n_rreq);
    chk("wraps total", 32'h3, n_wrap);
    rchk(C2, ctl(0, 0, 0), "flag auto clear");
    chk("irq events", 32'h1, irq_out);
    rchk(ST, 32'h3, "status both");
    apb(1'b1, CN, 32'h5A);
    rstn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rchk(C2, ctl(0, 0, 0), "ctrl2 rereset");
    rchk(CN, 32'h0, "counter rereset");
    rchk(MK, 32'h0, "mask rereset");
    final_report();
  end
endmodule

`default_nettype wire
